// ### pkg/hbs_pkg.sv
// ----------------------------------------------------------------
// Brake sequencer constants
// ----------------------------------------------------------------
package hbs_pkg;
  // Clock and tick timing
  localparam int CLK_PERIOD_PS = 5000; // 200 MHz master clock
  localparam int TICK_MS = 1; // Common timer tick in ms
  localparam int TICK_CYCLES = (TICK_MS * 1000000000) / CLK_PERIOD_PS;
  // Field widths
  localparam int SPEED_W = 14; // Speed in rpm
  localparam int DELAY_W = 14; // Delay in ms
  localparam int WAIT_W = 7; // Wait in 10 ms units
  localparam int ASSIGN_W = 3; // Terminal assignment digit
  localparam int N_TERM = 6; // General output terminals
  // Brake-to-de-energize delay
  localparam logic [DELAY_W-1:0] DELAY_MAX = 14'h2710; // 10000 ms
  localparam logic [DELAY_W-1:0] DELAY_RST = 14'h0000;
  // Brake speed threshold
  localparam logic [SPEED_W-1:0] THR_MAX = 14'h2710; // 10000 rpm
  localparam logic [SPEED_W-1:0] THR_RST = 14'h0064; // 100 rpm
  // De-energize-to-brake wait
  localparam logic [WAIT_W-1:0] WAIT_MIN = 7'h0a;
  localparam logic [WAIT_W-1:0] WAIT_MAX = 7'h64;
  localparam logic [WAIT_W-1:0] WAIT_RST = 7'h32;
  localparam logic [DELAY_W-1:0] WAIT_UNIT_MS = 14'h000a;
  // Output terminal assignment
  localparam logic [ASSIGN_W-1:0] ASSIGN_RST = 3'h2;
  localparam logic [ASSIGN_W-1:0] ASSIGN_OFF = 3'h6;
  // Motor stop methods
  typedef enum logic [1:0] {
    STOP_SHORT = 2'h0, // Windings short-circuited
    STOP_COAST = 2'h1, // Free coast
    STOP_ZERO = 2'h2, // Zero speed command
    STOP_DECEL = 2'h3 // Emergency torque decel
  } hbs_stop_type;
  // State after motor stop
  typedef enum logic [1:0] {
    POST_SHORT = 2'h0,
    POST_FREE = 2'h1,
    POST_ZERO_POS = 2'h2
  } hbs_post_type;
  // Sequencer states
  typedef enum logic [4:0] {
    ST_OFF = 5'h01, // Servo off, brake applied
    ST_ON = 5'h02, // Servo on, brake released
    ST_DELAY = 5'h04, // Brake applied, still energized
    ST_ZSTOP = 5'h08, // Zero speed decel, energized
    ST_AWAIT = 5'h10 // De-energized, brake still released
  } hbs_state_type;
endpackage : hbs_pkg

// ### verification/hbs_motor_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Motor and holding brake seen by the sequencer
// ----------------------------------------------------------------
module hbs_motor_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // From the sequencer
  input wire logic motor_energized,
  input wire logic brake_release_out,
  // Speed the host asks for
  input wire logic [hbs_pkg::SPEED_W-1:0] speed_cmd,
  // Measured speed
  output logic [hbs_pkg::SPEED_W-1:0] motor_speed
);
  // Powered motor tracks the command, unpowered one stops at once if braked, else coasts down
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      motor_speed <= 14'h0000;
    end else if (motor_energized) begin
      motor_speed <= speed_cmd;
    end else if (!brake_release_out) begin
      // Engaged brake holds the shaft
      motor_speed <= 14'h0000;
    end else if (motor_speed != 14'h0000) begin
      // Friction loses 1 rpm a cycle
      motor_speed <= motor_speed - 14'h0001;
    end
  end
endmodule : hbs_motor_model

// ### verification/test_hbs_brake_seq.sv
`timescale 1ns/1ps
`define CHK(a, e) check_val(16'(a), 16'(e))
module test_hbs_brake_seq;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int TK = 4; // Cycles per 1 ms tick in this run
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic servo_on_command = 1'b0;
  logic servo_off_command = 1'b0;
  logic alarm = 1'b0;
  logic alarm_zero_speed_ok = 1'b0;
  logic overtravel = 1'b0;
  logic [13:0] speed_cmd = 14'h0000; // Host speed request
  logic [13:0] motor_speed;
  logic [13:0] motor_max_speed = 14'h2710;
  logic [13:0] brake_to_deenergize_delay = 14'h0000;
  logic [13:0] brake_speed_threshold = 14'h0064;
  logic [6:0] deenergize_to_brake_wait = 7'h32;
  logic [2:0] output_assign_config = 3'h2;
  logic [1:0] stop_method_select = 2'h0;
  logic [5:0] other_terminal_signals = 6'h00;
  logic brake_release_out;
  logic motor_energized;
  logic overtravel_hold;
  logic [5:0] general_output_terminal;
  logic [1:0] stop_method_active;
  logic [1:0] post_stop_state;
  int fail_count = 0;
  int cmp_count = 0;
  int n;
  // Free running clock, 5 ns period
  always #2.5 mclk = ~mclk;
  // ----------------------------------------------------------------
  // Design and motor
  // ----------------------------------------------------------------
  hbs_brake_seq #(.TICK_CYCLES(TK)) dut (.mclk(mclk), .resetn(resetn),
    .servo_on_command(servo_on_command), .servo_off_command(servo_off_command), .alarm(alarm),
    .alarm_zero_speed_ok(alarm_zero_speed_ok), .overtravel(overtravel), .motor_speed(motor_speed),
    .motor_max_speed(motor_max_speed), .brake_to_deenergize_delay(brake_to_deenergize_delay),
    .brake_speed_threshold(brake_speed_threshold), .deenergize_to_brake_wait(deenergize_to_brake_wait),
    .output_assign_config(output_assign_config), .stop_method_select(stop_method_select),
    .other_terminal_signals(other_terminal_signals), .brake_release_out(brake_release_out),
    .motor_energized(motor_energized), .overtravel_hold(overtravel_hold),
    .general_output_terminal(general_output_terminal), .stop_method_active(stop_method_active),
    .post_stop_state(post_stop_state));
  hbs_motor_model motor (.mclk(mclk), .resetn(resetn), .motor_energized(motor_energized),
    .brake_release_out(brake_release_out), .speed_cmd(speed_cmd), .motor_speed(motor_speed));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Compare and count
  task automatic check_val(input logic [15:0] act, input logic [15:0] exp);
    cmp_count++;
    if (act !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, act, exp);
    end
  endtask : check_val
  // Counts then verdict
  task automatic print_verdict();
    $display("comparisons=%0d mismatches=%0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict
  // Reset for 16 cycles, clearing the host side
  task automatic reset_dut();
    @(posedge mclk);
    resetn <= 1'b0;
    alarm <= 1'b0;
    speed_cmd <= 14'h0000;
    overtravel <= 1'b0;
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
  endtask : reset_dut
  // Servo on pulse, then the host settle time
  task automatic svon();
    @(posedge mclk);
    servo_on_command <= 1'b1;
    @(posedge mclk);
    servo_on_command <= 1'b0;
    #1;
    `CHK({motor_energized, brake_release_out}, 2'b11);
    repeat (51 * TK) @(posedge mclk);
  endtask : svon
  // Servo off pulse
  task automatic svoff();
    @(posedge mclk);
    servo_off_command <= 1'b1;
    @(posedge mclk);
    servo_off_command <= 1'b0;
    #1;
  endtask : svoff
  // Cycles until brake (0) or power (1) drops, bounded
  task automatic wait_fall(input bit sel, output int cnt);
    cnt = 0;
    while ((sel ? motor_energized : brake_release_out) !== 1'b0 && cnt < 3000) begin
      @(posedge mclk);
      #1;
      cnt++;
    end
  endtask : wait_fall
  // Alarm while rotating with a coasting stop
  task automatic alarm_run(input logic [13:0] thr, input logic [13:0] mx, input logic [6:0] wt,
                           input logic [13:0] spd, output int cnt);
    reset_dut();
    brake_speed_threshold <= thr;
    motor_max_speed <= mx;
    deenergize_to_brake_wait <= wt;
    stop_method_select <= 2'h1;
    alarm_zero_speed_ok <= 1'b0;
    svon();
    @(posedge mclk);
    speed_cmd <= spd;
    repeat (3) @(posedge mclk);
    alarm <= 1'b1;
    @(posedge mclk);
    #1;
    `CHK({motor_energized, brake_release_out}, 2'b01);
    wait_fall(1'b0, cnt);
  endtask : alarm_run
  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (30000) @(posedge mclk);
    fail_count++;
    print_verdict();
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    // Every assignment digit, fixed at reset
    for (int c = 0; c < 8; c++) begin
      output_assign_config <= 3'(c);
      reset_dut();
      svon();
      `CHK(general_output_terminal, (c < 6) ? (6'h01 << c) : 6'h00);
    end
    $display("test routing done");
    // Default terminal, later change ignored, OR with others
    output_assign_config <= 3'h2;
    reset_dut();
    svon();
    @(posedge mclk);
    output_assign_config <= 3'h5;
    other_terminal_signals <= 6'h21;
    overtravel <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    `CHK(general_output_terminal, 6'h25);
    `CHK({brake_release_out, overtravel_hold}, 2'b11);
    brake_to_deenergize_delay <= 14'h0003;
    svoff();
    `CHK({brake_release_out, motor_energized}, 2'b01);
    `CHK(general_output_terminal, 6'h21);
    wait_fall(1'b1, n);
    `CHK(n inside {[9:17]}, 1'b1);
    other_terminal_signals <= 6'h00;
    $display("test servo off done");
    // Alarm while stopped ignores the delay
    svon();
    @(posedge mclk);
    alarm <= 1'b1;
    @(posedge mclk);
    #1;
    `CHK({brake_release_out, motor_energized}, 2'b00);
    $display("test alarm stopped done");
    // Each stop method taken from the selector
    for (int m = 0; m < 4; m++) begin
      reset_dut();
      stop_method_select <= 2'(m);
      svon();
      svoff();
      `CHK(stop_method_active, m);
      // Alarm in the delay ends it at once for method 3
      @(posedge mclk);
      alarm <= (m == 3);
      wait_fall(1'b1, n);
      `CHK((m == 3) ? (n == 1) : (n inside {[9:17]}), 1'b1);
      `CHK(post_stop_state, (m == 0) ? 0 : 1);
    end
    $display("test stop methods done");
    // Brake once speed falls below the threshold
    alarm_run(14'h0064, 14'h2710, 7'h32, 14'h01f4, n);
    `CHK(motor_speed inside {[90:99]}, 1'b1);
    // Threshold above the motor maximum is clamped
    alarm_run(14'h2710, 14'h012c, 7'h32, 14'h01f4, n);
    `CHK(motor_speed inside {[290:299]}, 1'b1);
    // Wait time expires first: 10 x 10 ms
    alarm_run(14'h0000, 14'h2710, 7'h0a, 14'h07d0, n);
    `CHK(n inside {[396:410]}, 1'b1);
    $display("test rotating alarm done");
    // Zero speed stop, then the delay after standstill
    reset_dut();
    brake_to_deenergize_delay <= 14'h0003;
    alarm_zero_speed_ok <= 1'b1;
    stop_method_select <= 2'h0;
    svon();
    @(posedge mclk);
    speed_cmd <= 14'h01f4;
    repeat (3) @(posedge mclk);
    alarm <= 1'b1;
    @(posedge mclk);
    #1;
    `CHK({motor_energized, brake_release_out, stop_method_active}, 4'b1110);
    @(posedge mclk);
    speed_cmd <= 14'h0000;
    wait_fall(1'b0, n);
    `CHK({motor_energized, post_stop_state}, 3'b110);
    wait_fall(1'b1, n);
    `CHK(n inside {[9:17]}, 1'b1);
    $display("test zero speed stop done");
    print_verdict();
  end
endmodule : test_hbs_brake_seq

// ### verilog/hbs_brake_seq.sv
`timescale 1ns/1ps
// Behaviour
// - Brake engages when servo off or alarm
// - Brake stays released during overtravel
// - Route brake to terminal 0-5, 6 off
// - Terminal is OR of assigned signals
// - Stopped servo off: brake first, delayed de-energize
// - Alarm de-energizes at once, ignoring delay, except for zero speed stops
// - Rotating alarm: brake below speed threshold
// - Rotating alarm: brake after wait time
// - Zero speed stop: delay after motor stops
// - Threshold clamped to motor maximum speed
// - Four stop methods supported
// - Three post-stop states reported
// - Zero speed stop default for permitting alarms
// - Servo off stop method from selector
module hbs_brake_seq #(
  parameter int TICK_CYCLES = hbs_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Host commands
  input wire logic servo_on_command,
  input wire logic servo_off_command,
  // Drive status
  input wire logic alarm,
  input wire logic alarm_zero_speed_ok,
  input wire logic overtravel,
  input wire logic [hbs_pkg::SPEED_W-1:0] motor_speed,
  input wire logic [hbs_pkg::SPEED_W-1:0] motor_max_speed,
  // Configuration
  input wire logic [hbs_pkg::DELAY_W-1:0] brake_to_deenergize_delay,
  input wire logic [hbs_pkg::SPEED_W-1:0] brake_speed_threshold,
  input wire logic [hbs_pkg::WAIT_W-1:0] deenergize_to_brake_wait,
  input wire logic [hbs_pkg::ASSIGN_W-1:0] output_assign_config,
  input wire logic [1:0] stop_method_select,
  // Other signals per terminal
  input wire logic [hbs_pkg::N_TERM-1:0] other_terminal_signals,
  // Outputs
  output logic brake_release_out,
  output logic motor_energized,
  output logic overtravel_hold,
  output logic [hbs_pkg::N_TERM-1:0] general_output_terminal,
  output logic [1:0] stop_method_active,
  output logic [1:0] post_stop_state
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  hbs_pkg::hbs_state_type state_reg, state_next; // Sequencer state
  logic [hbs_pkg::DELAY_W-1:0] ms_reg, ms_next; // Ms since entry
  hbs_pkg::hbs_stop_type method_reg, method_next; // Applied method
  logic [hbs_pkg::ASSIGN_W-1:0] assign_reg, assign_next; // Latched route
  logic cfg_done_reg, cfg_done_next; // Route captured
  logic release_reg, release_next;
  logic energ_reg, energ_next;
  logic ot_reg, ot_next;
  logic [1:0] post_reg, post_next;
  logic [hbs_pkg::N_TERM-1:0] term_reg, term_next;
  logic tick; // 1 ms tick
  logic moving; // Motor rotating
  logic [hbs_pkg::SPEED_W-1:0] thr_eff; // Clamped threshold
  logic [hbs_pkg::DELAY_W-1:0] delay_eff; // Clamped delay
  logic [hbs_pkg::WAIT_W-1:0] wait_eff; // Clamped wait
  logic [hbs_pkg::DELAY_W-1:0] wait_ms; // Wait in ms
  hbs_pkg::hbs_stop_type alarm_method; // Method for alarm stop
  hbs_pkg::hbs_stop_type stop_method; // Method for this stop

  // ----------------------------------------------------------------
  // Tick and derived settings
  // ----------------------------------------------------------------
  hbs_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .mclk(mclk),
    .resetn(resetn),
    .tick(tick)
  );

  // Clamp settings into range
  always_comb begin
    moving = (motor_speed != '0);
    thr_eff = (brake_speed_threshold > hbs_pkg::THR_MAX) ? hbs_pkg::THR_MAX : brake_speed_threshold;
    if (thr_eff > motor_max_speed) begin
      thr_eff = motor_max_speed;
    end
    delay_eff = (brake_to_deenergize_delay > hbs_pkg::DELAY_MAX) ? hbs_pkg::DELAY_MAX
                                                                   : brake_to_deenergize_delay;
    if (deenergize_to_brake_wait < hbs_pkg::WAIT_MIN) begin
      wait_eff = hbs_pkg::WAIT_MIN;
    end else if (deenergize_to_brake_wait > hbs_pkg::WAIT_MAX) begin
      wait_eff = hbs_pkg::WAIT_MAX;
    end else begin
      wait_eff = deenergize_to_brake_wait;
    end
    wait_ms = hbs_pkg::DELAY_W'(hbs_pkg::DELAY_W'(wait_eff) * hbs_pkg::WAIT_UNIT_MS);
    // Zero speed where the alarm allows it, else the selector
    alarm_method = alarm_zero_speed_ok ? hbs_pkg::STOP_ZERO
                                       : hbs_pkg::hbs_stop_type'(stop_method_select);
    stop_method = alarm ? alarm_method : hbs_pkg::hbs_stop_type'(stop_method_select);
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Next state, timer and applied method
  always_comb begin
    state_next = state_reg;
    method_next = method_reg;
    unique case (state_reg)
      hbs_pkg::ST_OFF: begin
        // Servo on refused while alarm stands
        if (servo_on_command && !servo_off_command && !alarm) begin
          state_next = hbs_pkg::ST_ON;
        end
      end
      hbs_pkg::ST_ON: begin
        // Stop on alarm or servo off
        if (alarm || servo_off_command) begin
          method_next = stop_method;
          if (moving && stop_method == hbs_pkg::STOP_ZERO) begin
            state_next = hbs_pkg::ST_ZSTOP;
          end else if (moving) begin
            state_next = hbs_pkg::ST_AWAIT;
          end else if (alarm) begin
            state_next = hbs_pkg::ST_OFF;
          end else begin
            state_next = hbs_pkg::ST_DELAY;
          end
        end
      end
      hbs_pkg::ST_DELAY: begin
        // Hold energized until delay runs out or an alarm ends a non-zero-speed stop
        if (alarm && method_reg != hbs_pkg::STOP_ZERO) begin
          state_next = hbs_pkg::ST_OFF;
        end else if (ms_reg >= delay_eff) begin
          state_next = hbs_pkg::ST_OFF;
        end
      end
      hbs_pkg::ST_ZSTOP: begin
        // Decelerate to stop, then brake and delay
        if (!moving) begin
          state_next = hbs_pkg::ST_DELAY;
        end
      end
      hbs_pkg::ST_AWAIT: begin
        // Whichever comes first: slow enough or waited out
        if (motor_speed < thr_eff) begin
          state_next = hbs_pkg::ST_OFF;
        end else if (ms_reg >= wait_ms) begin
          state_next = hbs_pkg::ST_OFF;
        end
      end
    endcase
    // Ms counter restarts on every state change
    if (state_next != state_reg) begin
      ms_next = '0;
    end else if (tick && ms_reg != '1) begin
      ms_next = ms_reg + hbs_pkg::DELAY_W'(1);
    end else begin
      ms_next = ms_reg;
    end
  end

  // Register sequencer
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= hbs_pkg::ST_OFF;
      ms_reg <= '0;
      method_reg <= hbs_pkg::STOP_SHORT;
    end else begin
      state_reg <= state_next;
      ms_reg <= ms_next;
      method_reg <= method_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs and terminal routing
  // ----------------------------------------------------------------
  // Output values from next state
  always_comb begin
    // Released while on, overtravel included, and during zero speed decel and await, applied in delay
    release_next = (state_next == hbs_pkg::ST_ON) ||
                   (state_next == hbs_pkg::ST_ZSTOP) || (state_next == hbs_pkg::ST_AWAIT);
    energ_next = (state_next == hbs_pkg::ST_ON) || (state_next == hbs_pkg::ST_ZSTOP) ||
                 (state_next == hbs_pkg::ST_DELAY);
    ot_next = overtravel && (state_next == hbs_pkg::ST_ON);
    // Post-stop state
    if (state_next == hbs_pkg::ST_DELAY) begin
      post_next = hbs_pkg::POST_ZERO_POS;
    end else if (method_next == hbs_pkg::STOP_SHORT) begin
      post_next = hbs_pkg::POST_SHORT;
    end else begin
      post_next = hbs_pkg::POST_FREE;
    end
    // Route captured once after reset
    cfg_done_next = 1'b1;
    assign_next = cfg_done_reg ? assign_reg : output_assign_config;
  end

  // Per-terminal OR of assigned signals
  for (genvar gi = 0; gi < hbs_pkg::N_TERM; gi++) begin : g_term
    always_comb begin
      // Route as it stands after this edge, so a first-edge servo on lands right
      term_next[gi] = other_terminal_signals[gi] ||
                      (release_next && assign_next == hbs_pkg::ASSIGN_W'(gi));
    end
  end

  // Register outputs
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      release_reg <= 1'b0;
      energ_reg <= 1'b0;
      ot_reg <= 1'b0;
      post_reg <= hbs_pkg::POST_SHORT;
      cfg_done_reg <= 1'b0;
      assign_reg <= hbs_pkg::ASSIGN_RST;
      term_reg <= '0;
    end else begin
      release_reg <= release_next;
      energ_reg <= energ_next;
      ot_reg <= ot_next;
      post_reg <= post_next;
      cfg_done_reg <= cfg_done_next;
      assign_reg <= assign_next;
      term_reg <= term_next;
    end
  end

  assign brake_release_out = release_reg;
  assign motor_energized = energ_reg;
  assign overtravel_hold = ot_reg;
  assign general_output_terminal = term_reg;
  assign stop_method_active = method_reg;
  assign post_stop_state = post_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence stopped_off_s;
    state_reg == hbs_pkg::ST_ON && servo_off_command && !alarm && !moving;
  endsequence
  sequence zstop_done_s;
    state_reg == hbs_pkg::ST_ZSTOP && !moving;
  endsequence

  brake_on_alarm_a: assert property (state_reg == hbs_pkg::ST_ON && alarm && !moving
    |=> !brake_release_out && !motor_energized) else $error("brake not applied on alarm");
  ot_release_a: assert property (state_reg == hbs_pkg::ST_ON && overtravel && !alarm && !servo_off_command
    |=> brake_release_out && overtravel_hold) else $error("brake applied during overtravel");
  route_a: assert property (brake_release_out && assign_reg < hbs_pkg::ASSIGN_OFF
    |-> general_output_terminal[assign_reg]) else $error("brake not on assigned terminal");
  or_term_a: assert property (##1 (general_output_terminal & $past(other_terminal_signals))
    == $past(other_terminal_signals)) else $error("terminal lost other signal");
  delay_seq_a: assert property (stopped_off_s |=> !brake_release_out && motor_energized
    && state_reg == hbs_pkg::ST_DELAY) else $error("servo off delay sequence wrong");
  alarm_deen_a: assert property (state_reg == hbs_pkg::ST_ON && alarm && moving
    && alarm_method != hbs_pkg::STOP_ZERO |=> !motor_energized && brake_release_out)
    else $error("alarm did not de-energize");
  speed_brake_a: assert property (state_reg == hbs_pkg::ST_AWAIT && motor_speed < thr_eff
    |=> !brake_release_out) else $error("brake late below threshold");
  wait_brake_a: assert property (state_reg == hbs_pkg::ST_AWAIT && ms_reg >= wait_ms
    |=> !brake_release_out) else $error("brake late after wait");
  zstop_delay_a: assert property (zstop_done_s |=> state_reg == hbs_pkg::ST_DELAY
    && motor_energized && !brake_release_out) else $error("zero stop delay wrong");
  thr_clamp_a: assert property (thr_eff <= motor_max_speed)
    else $error("threshold above motor maximum");
  tick_gap_a: assert property (tick |=> !tick)
    else $error("tick pulses back to back");
endmodule : hbs_brake_seq

// ### verilog/hbs_tick.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Millisecond tick generator
// ----------------------------------------------------------------
module hbs_tick #(
  parameter int TICK_CYCLES = hbs_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Tick out
  output logic tick
);
  localparam int CW = $clog2(TICK_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

  logic [CW-1:0] cnt_reg; // Cycle counter
  logic [CW-1:0] cnt_next;
  logic tick_reg; // One-cycle tick
  logic tick_next;

  // Count cycles, pulse on wrap
  always_comb begin
    tick_next = (cnt_reg == LAST);
    cnt_next = tick_next ? '0 : cnt_reg + CW'(1);
  end

  // Register counter
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;
endmodule : hbs_tick
